/* File: sipo_pkg.sv */
// Shared constants and carriers for the serial-in, parallel-out shift/store block.
// Assumes a single core clock; all pin inputs are asynchronous to it.
package sipo_pkg;

  // Register widths and the event queue depth
  localparam int SIPO_WIDTH = 8;
  localparam int SIPO_EVQ_DEPTH = 8;

  // Reset and clear values of both registers
  localparam logic [SIPO_WIDTH-1:0] SIPO_SHIFT_RESET = 8'h00;
  localparam logic [SIPO_WIDTH-1:0] SIPO_STORE_RESET = 8'h00;

  // Bit positions inside the parallel word
  localparam int SIPO_FIRST_STAGE = 0;
  localparam int SIPO_LAST_STAGE = SIPO_WIDTH - 1;

  // Synchroniser depth for pin inputs
  localparam int SIPO_SYNC_STAGES = 2;

  // Pin levels after synchronisation
  typedef struct packed {
    logic serial_in;
    logic shift_clk;
    logic store_clk;
    logic shift_clear_n;
    logic store_clear_n;
  } sipo_pins_t;

  // One queued clock event with the serial level seen one cycle before its edge
  typedef struct packed {
    logic serial_bit;
    logic shift_edge;
    logic store_edge;
  } sipo_event_t;

  localparam int SIPO_EVENT_BITS = $bits(sipo_event_t);

endpackage : sipo_pkg

/* File: sipo_fifo.sv */
// Small flop-based FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sipo_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Status
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  assign level = count;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + CW'(1);
    end else if (pop && !push) begin
      count <= count - CW'(1);
    end
  end
endmodule // sipo_fifo
`default_nettype wire

/* File: sipo_shift_store.sv */
// Serial-in, parallel-out shift register feeding an 8-bit storage register.
// Assumes pin inputs are asynchronous to core_clk and toggle slower than it.
// Notes on behaviour
// - Storage clear low holds all parallel outputs at zero.
// - Shift clear low holds every shift stage at zero.
// - Shift clock rise loads serial input into first stage, others move up.
// - Store clock rise with both clears high copies all stages to output.
// - Simultaneous edges: output takes pre-shift contents, shift proceeds.
// - Without a shift clock rise the shift register holds.
// - Without a store clock rise the output register holds.
// - Cascade output feeds next device's serial input; clocks shared.
// - Output keeps its stored value while shifting, until next store rise.
// - Both registers are eight bits, shift feeding store in parallel.
// - Clears are active low and override clocks from the third core edge.
// - Clocks are rising-edge; tied clocks make output lag one pulse.
// - Cascade output always shows the last shift stage.
`timescale 1ns/1ps
`default_nettype none
module sipo_shift_store
  import sipo_pkg::*;
#(
  parameter int WIDTH = SIPO_WIDTH,
  parameter int EVQ_DEPTH = SIPO_EVQ_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Device pins
  input wire logic serial_in,
  input wire logic shift_clk,
  input wire logic store_clk,
  input wire logic shift_clear_n,
  input wire logic store_clear_n,
  // Outputs to the pins
  output logic [WIDTH-1:0] parallel_out,
  output logic cascade_out,
  // Event queue flow control
  input wire logic apply_hold,
  output logic event_ready,
  output logic event_pending
);
  import sipo_pkg::*;

  sipo_pins_t pins_raw;
  sipo_pins_t pins_sync;
  sipo_pins_t pins_prev;
  sipo_event_t ev_in;
  sipo_event_t ev_out;
  logic ev_in_valid;
  logic ev_out_valid;
  logic ev_out_ready;
  logic [SIPO_EVENT_BITS-1:0] ev_out_bits;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] store_reg;
  logic [WIDTH-1:0] next_shift;
  logic [WIDTH-1:0] next_store;
  logic do_shift;
  logic do_store;
  logic shift_cleared;
  logic store_cleared;
  logic store_allowed;

  // Timing, counted in core cycles from a pin change:
  //   edge 1 catches the level in the first flop, edge 2 in the second;
  //   edge 3 pushes a rising clock into the queue;
  //   edge 4 applies it unless the consumer holds the queue.
  // A clear level reaches its register at edge 3, ahead of any queued edge.
  // Hazards a user must know:
  //   - each pin level must stand at least two core cycles, or it is missed;
  //   - with the queue full, further clock rises are dropped, not delayed;
  //   - the serial bit is the level seen one cycle before the rise, so the
  //     controller must set data before raising the shift clock.
  // Clears are level driven here, not truly asynchronous: they trade the
  // instant response of the pin for a design with one clock and no
  // reset-recovery paths.

  // Pin levels gathered into one word so all pins see the same latency
  always_comb begin
    pins_raw = '0;
    pins_raw.serial_in = serial_in;
    pins_raw.shift_clk = shift_clk;
    pins_raw.store_clk = store_clk;
    pins_raw.shift_clear_n = shift_clear_n;
    pins_raw.store_clear_n = store_clear_n;
  end

  // Two-flop synchroniser per pin; the first flop feeds only the second,
  // and a third flop keeps last cycle's level for edge detection
  for (genvar p = 0; p < $bits(sipo_pins_t); p++) begin : g_pin
    logic meta_bit;
    logic sync_bit;
    logic prev_bit;

    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        meta_bit <= 1'b0;
        sync_bit <= 1'b0;
      end else begin
        meta_bit <= pins_raw[p];
        sync_bit <= meta_bit;
      end
    end

    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        prev_bit <= 1'b0;
      end else begin
        prev_bit <= sync_bit;
      end
    end

    assign pins_sync[p] = sync_bit;
    assign pins_prev[p] = prev_bit;
  end

  // Only rising edges form events; falls and steady levels do nothing
  always_comb begin
    ev_in.serial_bit = pins_prev.serial_in;
    ev_in.shift_edge = pins_sync.shift_clk && !pins_prev.shift_clk;
    ev_in.store_edge = pins_sync.store_clk && !pins_prev.store_clk;
  end
  assign ev_in_valid = ev_in.shift_edge || ev_in.store_edge;

  // Events queue here so a held consumer loses no clock edges until EVQ_DEPTH events are waiting
  sipo_fifo #(
    .WIDTH(SIPO_EVENT_BITS),
    .DEPTH(EVQ_DEPTH)
  ) u_evq (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(ev_in_valid),
    .in_ready(event_ready),
    .in_data(ev_in),
    .out_valid(ev_out_valid),
    .out_ready(ev_out_ready),
    .out_data(ev_out_bits),
    .level()
  );

  assign ev_out = sipo_event_t'(ev_out_bits);
  assign ev_out_ready = !apply_hold;
  assign event_pending = ev_out_valid;

  // A queued edge takes effect only on the cycle the queue hands it over
  assign do_shift = ev_out_valid && ev_out_ready && ev_out.shift_edge;
  assign do_store = ev_out_valid && ev_out_ready && ev_out.store_edge;

  // Clears bypass the queue so they act as soon as they are seen
  assign shift_cleared = !pins_sync.shift_clear_n;
  assign store_cleared = !pins_sync.store_clear_n;
  // A store edge while the shift stages are held clear leaves the output alone
  assign store_allowed = do_store && !shift_cleared;

  // Per stage: the first stage takes the queued serial bit, the others take
  // their lower neighbour; the store copy reads each stage before it moves,
  // so tied clocks leave the output one pulse behind
  for (genvar g = 0; g < WIDTH; g++) begin : g_stage
    logic shift_bit;
    logic store_bit;

    if (g == SIPO_FIRST_STAGE) begin : g_first
      assign next_shift[g] = ev_out.serial_bit;
    end else begin : g_rest
      assign next_shift[g] = shift_reg[g-1];
    end
    assign next_store[g] = shift_reg[g];

    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        shift_bit <= SIPO_SHIFT_RESET[g];
      end else if (shift_cleared) begin
        shift_bit <= SIPO_SHIFT_RESET[g];
      end else if (do_shift) begin
        shift_bit <= next_shift[g];
      end
    end

    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        store_bit <= SIPO_STORE_RESET[g];
      end else if (store_cleared) begin
        store_bit <= SIPO_STORE_RESET[g];
      end else if (store_allowed) begin
        store_bit <= next_store[g];
      end
    end

    assign shift_reg[g] = shift_bit;
    assign store_reg[g] = store_bit;
  end

  assign parallel_out = store_reg;
  assign cascade_out = shift_reg[SIPO_LAST_STAGE];
endmodule // sipo_shift_store
`default_nettype wire

/* File: sipo_checker_sva.sv */
// Checker on the shift/store block ports.
// Assumes pin levels stand 3 or more core cycles.
`timescale 1ns/1ps
`default_nettype none
module sipo_checker #(parameter int WIDTH = 8) (
  // Clock, reset
  input wire logic core_clk,
  input wire logic nrst,
  // Pins
  input wire logic serial_in,
  input wire logic shift_clk,
  input wire logic store_clk,
  input wire logic shift_clear_n,
  input wire logic store_clear_n,
  input wire logic apply_hold,
  // Results
  input wire logic [WIDTH-1:0] parallel_out,
  input wire logic cascade_out,
  input wire logic event_ready,
  input wire logic event_pending
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_store_clear_zero:
    assert property (!store_clear_n [*5] |-> parallel_out == '0) else $error("out kept");
  a_shift_clear_zero:
    assert property (!shift_clear_n [*5] |-> !cascade_out) else $error("shift kept");
  a_clear_prompt:
    assert property ($fell(store_clear_n) |-> ##[1:5] parallel_out == '0) else $error("slow");
  a_shift_hold:
    assert property (($stable(shift_clk) && shift_clear_n && !event_pending) [*6] |=>
      $stable(cascade_out)) else $error("shift moved");
  a_store_hold:
    assert property (($stable(store_clk) && store_clear_n && !event_pending) [*6] |=>
      $stable(parallel_out)) else $error("out moved");
  a_edge_queued:
    assert property ($rose(shift_clk) && shift_clear_n && event_ready |-> ##[1:5]
      event_pending) else $error("edge lost");
  a_ready_empty:
    assert property (!event_pending |-> event_ready) else $error("ready low");
  a_reset_state:
    assert property ($rose(nrst) |-> parallel_out == '0 && !cascade_out && !event_pending)
      else $error("reset state");
  c_both: cover property ($rose(shift_clk) && $rose(store_clk));
  c_full: cover property (!event_ready);
  c_store: cover property ($rose(store_clk) && store_clear_n);
endmodule // sipo_checker
bind sipo_shift_store sipo_checker #(.WIDTH(WIDTH)) sipo_checker_inst (.*);
`default_nettype wire

/* File: sipo_ctrl_model.sv */
// Controller model driving the block's pins like GPIO lines.
// Assumes core_clk from the bench; pins change on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module sipo_ctrl_model (
  // Clock
  input wire logic core_clk,
  // Pins
  output logic serial_in,
  output logic shift_clk,
  output logic store_clk,
  output logic shift_clear_n,
  output logic store_clear_n
);
  initial {serial_in, shift_clk, store_clk, shift_clear_n, store_clear_n} = 5'h03;
  // Each level stands 4 cycles so the synchronisers catch it
  task automatic drive(input logic [4:0] v);
    @(negedge core_clk);
    {serial_in, shift_clk, store_clk, shift_clear_n, store_clear_n} = v;
    repeat (3) @(negedge core_clk);
  endtask
  // Data is not left holding after the pulse: it flips
  task automatic pulse(input logic b, input logic sh, input logic st);
    drive({b, 4'h3});
    drive({b, sh, st, 2'h3});
    drive({~b, 4'h3});
  endtask
  task automatic clear_all;
    drive(5'h00);
    drive(5'h03);
  endtask
endmodule // sipo_ctrl_model
`default_nettype wire

/* File: sipo_shift_store_bench.sv */
// Bench for the shift/store block with the controller model on its pins.
// Assumes package, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sipo_shift_store_bench;
  import sipo_pkg::*;
  logic core_clk, nrst, apply_hold, cascade_out, event_ready, event_pending;
  logic serial_in, shift_clk, store_clk, shift_clear_n, store_clear_n;
  logic [SIPO_WIDTH-1:0] parallel_out;
  int err_total, tests_run;
  sipo_ctrl_model sipo_ctrl_model_inst (.*);
  sipo_shift_store sipo_shift_store_inst (.*);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic conclude;
    $display("mismatches %0d, checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle;
    int n;
    n = 0;
    while (event_pending !== 1'b0 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    if (event_pending !== 1'b0) begin
      err_total++;
      conclude();
    end
    repeat (2) @(negedge core_clk);
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) sipo_ctrl_model_inst.pulse(b[i], 1'b1, 1'b0);
  endtask
  task automatic t_clear;
    sipo_ctrl_model_inst.clear_all();
    settle();
    chk("out", 8'h00, parallel_out);
    chk("cascade", 8'h00, {7'h0, cascade_out});
  endtask
  task automatic t_stages;
    send(8'hA5);
    chk("out", 8'h00, parallel_out);
    chk("cascade", 8'h01, {7'h0, cascade_out});
    sipo_ctrl_model_inst.pulse(1'b0, 1'b1, 1'b1);
    chk("out", 8'hA5, parallel_out);
    sipo_ctrl_model_inst.pulse(1'b1, 1'b0, 1'b1);
    chk("out", 8'h4A, parallel_out);
  endtask
  task automatic t_clears;
    sipo_ctrl_model_inst.drive(5'h02);
    settle();
    chk("out", 8'h00, parallel_out);
    sipo_ctrl_model_inst.pulse(1'b0, 1'b0, 1'b1);
    chk("out", 8'h4A, parallel_out);
    sipo_ctrl_model_inst.drive(5'h01);
    sipo_ctrl_model_inst.pulse(1'b0, 1'b0, 1'b1);
    chk("out", 8'h00, parallel_out);
  endtask
  task automatic t_queue;
    apply_hold = 1'b1;
    send(8'h3C);
    chk("ready", 8'h00, {7'h0, event_ready});
    chk("pending", 8'h01, {7'h0, event_pending});
    sipo_ctrl_model_inst.pulse(1'b1, 1'b1, 1'b0);
    apply_hold = 1'b0;
    settle();
    sipo_ctrl_model_inst.pulse(1'b0, 1'b0, 1'b1);
    chk("out", 8'h3C, parallel_out);
  endtask
  initial begin
    nrst = 1'b0;
    apply_hold = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    t_clear();
    t_stages();
    t_clears();
    t_queue();
    conclude();
  end
endmodule // sipo_shift_store_bench
`default_nettype wire
